// *** rtl/adcsc_pkg.sv ***
// Shared constants and types for the serial conversion controller.
// Assumes a 200 MHz system clock; the oscillator delay and half-period counts derive from that rate.
package adcsc_pkg;

   // ==========================================================
   // Command byte layout
   localparam int         CMD_W      = 8;
   localparam logic [7:0] CMD_RESET  = 8'h06;
   localparam int         CH_MSB     = 7;
   localparam int         CH_LSB     = 5;
   localparam int         SCAN_HI    = 4;
   localparam int         SCAN_LO    = 3;
   localparam int         CLKSRC_BIT = 0;

   // ==========================================================
   // Result framing
   localparam int RES_W      = 14;
   localparam int FRAME_BITS = 16;

   // ==========================================================
   // Serial clock and internal cycle numbers
   localparam logic [5:0] CNT_CH_APPLY  = 6'h03;
   localparam logic [5:0] CNT_W8        = 6'h08;
   localparam logic [5:0] CNT_W16       = 6'h10;
   localparam logic [5:0] SMP_EXT8      = 6'h06;
   localparam logic [5:0] SMP_EXT16     = 6'h0e;
   localparam logic [5:0] ACQ_ON_INT    = 6'h02;
   localparam logic [5:0] ACQ_END_INT8  = 6'h06;
   localparam logic [5:0] ACQ_END_INT16 = 6'h12;
   localparam logic [5:0] CONV_INT8     = 6'h19;
   localparam logic [5:0] CONV_INT16    = 6'h20;
   localparam logic [5:0] RCNT_MAX      = 6'h3f;
   localparam logic [4:0] BIT_LAST      = 5'h0f;

   // ==========================================================
   // Timing
   localparam int SYS_PERIOD_NS = 5;
   localparam int OSC_DLY_NS    = 125;
   localparam int OSC_PERIOD_NS = 250;
   localparam int OSC_DLY_CYC   =
      (OSC_DLY_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int OSC_HALF_CYC  = OSC_PERIOD_NS / (2 * SYS_PERIOD_NS);
   localparam int FIN_WAIT_CYC  = 2;
   localparam logic [4:0] OSC_DLY_LAST  = 5'(OSC_DLY_CYC - 1);
   localparam logic [4:0] OSC_HALF_LAST = 5'(OSC_HALF_CYC - 1);
   localparam logic [4:0] FIN_WAIT_LAST = 5'(FIN_WAIT_CYC);

   // ==========================================================
   // Pin sync reset value: chip select idles high
   localparam logic [4:0] PIN_RESET = 5'h10;

   // ==========================================================
   // Modes and states
   typedef enum logic [1:0] {
      SCAN_SINGLE, SCAN_UP_TO_N, SCAN_UPPER_TO_N, SCAN_REPEAT_N
   } adcsc_scan_e;

   typedef enum logic [2:0] {
      S_OFF, S_CMD, S_EXT_RD, S_OSC_DLY, S_INT_RUN, S_FINISH, S_INT_RD
   } adcsc_state_e;

endpackage

// *** rtl/adcsc_sync2.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes every bit is an independent level from outside sys_clk.
`timescale 1ns/1ps
`default_nettype none
module adcsc_sync2 #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Pins in, synchronised out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } adcsc_sync_s;

   adcsc_sync_s q;
   adcsc_sync_s n;

   // ==========================================================
   // First stage feeds only the second
   always_comb begin
      n        = q;
      n.meta   = async_in;
      n.stable = q.meta;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= {RESET_VAL, RESET_VAL};
      end else begin
         q <= n;
      end
   end

   assign sync_out = q.stable;
endmodule
`default_nettype wire

// *** rtl/adcsc_result_mem.sv ***
// Small result store for scan sequences, registered read port.
// Assumes one write and one read per cycle, same clock.
`timescale 1ns/1ps
`default_nettype none
module adcsc_result_mem #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 14,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // Read port
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   // ==========================================================
   // Storage needs no reset; contents are written before use
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule
`default_nettype wire

// *** rtl/adcsc_ctrl.sv ***
// Serial conversion control seen from the converter side.
// Assumes sclk far slower than sys_clk and an analog core that
// presents a finished result on adc_result when it is taken.
`timescale 1ns/1ps
`default_nettype none
module adcsc_ctrl
   import adcsc_pkg::*;
#(
   parameter int NUM_CH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Serial pins
   input  wire logic             cs_n,
   input  wire logic             sclk,
   input  wire logic             din,
   output logic                  dout,
   output logic                  dout_oe_n,
   output logic                  eoc_n,
   // Mode pins
   input  wire logic             frame_sync_in,
   input  wire logic             transfer_width_select,
   // Analog core
   input  wire logic [RES_W-1:0] adc_result,
   output logic [$clog2(NUM_CH)-1:0] mux_channel,
   output logic                  track,
   output logic                  analog_awake,
   output logic                  osc_run,
   output logic                  osc_clk,
   // Status
   output logic [CMD_W-1:0]      command_reg
);
   localparam int CH_W = $clog2(NUM_CH);
   localparam logic [CH_W-1:0] HALF_CH = CH_W'(NUM_CH / 2);
   localparam logic [CH_W:0]   ALL_CH  = (CH_W + 1)'(NUM_CH);
   localparam logic [CH_W:0]   ONE_CH  = (CH_W + 1)'(1);

   typedef struct packed {
      adcsc_state_e     state;
      logic             cs_q;
      logic             sclk_q;
      logic             wide;
      logic [7:0]       cmd;
      logic [7:0]       shin;
      logic [5:0]       rcnt;
      logic [CH_W-1:0]  ch;
      logic [CH_W-1:0]  widx;
      logic [CH_W-1:0]  ridx;
      logic [CH_W:0]    nleft;
      logic [CH_W:0]    nconv;
      logic             rep;
      logic [4:0]       tcnt;
      logic             iclk;
      logic [5:0]       icnt;
      logic [4:0]       bcnt;
      logic [15:0]      sh;
      logic [RES_W-1:0] res;
      logic             wr;
      logic             oe_n;
      logic             eoc_n;
      logic             awake;
      logic             osc;
      logic             acq;
   } adcsc_st_s;

   localparam adcsc_st_s ST_RST = '{
      state: S_OFF, cs_q: 1'b1, cmd: CMD_RESET,
      oe_n: 1'b1, eoc_n: 1'b1, default: '0
   };

   adcsc_st_s q;
   adcsc_st_s n;
   // ==========================================================
   // Pin synchronisers
   logic [4:0] pins_s;
   logic       s_cs, s_sclk, s_din, s_fsync, s_wide;
   adcsc_sync2 #(.WIDTH(5), .RESET_VAL(PIN_RESET)) u_sync (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .async_in ({cs_n, sclk, din, frame_sync_in,
                  transfer_width_select}),
      .sync_out (pins_s)
   );
   assign {s_cs, s_sclk, s_din, s_fsync, s_wide} = pins_s;
   // ==========================================================
   // Result store
   logic [RES_W-1:0] mem_rdata;

   adcsc_result_mem #(.DEPTH(NUM_CH), .WIDTH(RES_W)) u_mem (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .wr_en   (q.wr),
      .wr_addr (q.widx),
      .wr_data (q.res),
      .rd_addr (q.ridx),
      .rd_data (mem_rdata)
   );

   // ==========================================================
   // Edges and mode-dependent cycle numbers
   logic            sclk_rise, sclk_fall, cs_fall, upper_ok;
   logic [5:0]      rnext, cmd_end, smp_ext, acq_end, conv_end;
   logic [7:0]      cmd_now;
   logic [CH_W-1:0] chn, scan_first, ridx_next;
   adcsc_scan_e     scan_md;
   logic [CH_W:0]   scan_cnt;
   assign sclk_rise = s_sclk & ~q.sclk_q;
   assign sclk_fall = ~s_sclk & q.sclk_q;
   assign cs_fall   = ~s_cs & q.cs_q;
   assign rnext     = (q.rcnt == RCNT_MAX) ? q.rcnt : q.rcnt + 6'h01;
   assign cmd_end   = q.wide ? CNT_W16 : CNT_W8;
   assign smp_ext   = q.wide ? SMP_EXT16 : SMP_EXT8;
   assign acq_end   = q.wide ? ACQ_END_INT16 : ACQ_END_INT8;
   assign conv_end  = q.wide ? CONV_INT16 : CONV_INT8;
   assign cmd_now   = (q.state == S_CMD && sclk_rise && rnext == CNT_W8)
                    ? {q.shin[6:0], s_din} : q.cmd;
   // Scan decode; the ext path never consults it
   assign chn       = cmd_now[CH_MSB -: CH_W];
   assign scan_md   = adcsc_scan_e'(cmd_now[SCAN_HI:SCAN_LO]);
   assign upper_ok  = (chn >= HALF_CH);
   assign scan_first = (scan_md == SCAN_UP_TO_N) ? '0 :
                       (scan_md == SCAN_UPPER_TO_N && upper_ok)
                       ? HALF_CH : chn;
   assign scan_cnt  = (scan_md == SCAN_UP_TO_N) ? {1'b0, chn} + ONE_CH :
                      (scan_md == SCAN_UPPER_TO_N && upper_ok)
                      ? {1'b0, chn} - {1'b0, HALF_CH} + ONE_CH :
                      (scan_md == SCAN_REPEAT_N) ? ALL_CH : ONE_CH;
   assign ridx_next = ({1'b0, q.ridx} + ONE_CH == q.nconv)
                    ? '0 : q.ridx + CH_W'(1);

   // ==========================================================
   // Sequencer
   always_comb begin
      n        = q;
      n.cs_q   = s_cs;
      n.sclk_q = s_sclk;
      n.wr     = 1'b0;
      if (q.wr) begin
         n.widx = q.widx + CH_W'(1);
      end
      if (s_cs) begin
         // Abort anything in flight and power down
         n.state = S_OFF;
         n.oe_n  = 1'b1;
         n.awake = 1'b0;
         n.osc   = 1'b0;
         n.acq   = 1'b0;
         n.iclk  = 1'b0;
      end else if (cs_fall) begin
         // Frame sync low selects a mode this block lacks
         n.state = s_fsync ? S_CMD : S_OFF;
         n.awake = s_fsync;
         n.oe_n  = 1'b0;
         n.sh    = '0;
         n.rcnt  = '0;
         n.bcnt  = '0;
         n.eoc_n = 1'b1;
         n.wide  = s_wide;
      end else begin
         case (q.state)
            S_CMD, S_EXT_RD: begin
               n.cmd = cmd_now;
               if (sclk_rise) begin
                  n.rcnt = rnext;
                  if (q.rcnt < CNT_W8) begin
                     n.shin = {q.shin[6:0], s_din};
                  end
                  if (q.state == S_CMD && rnext == CNT_CH_APPLY) begin
                     n.ch  = {q.shin[CH_W-2:0], s_din};
                     n.acq = 1'b1;
                  end
                  if (q.state == S_CMD && rnext == cmd_end &&
                      cmd_now[CLKSRC_BIT]) begin
                     n.state = S_OSC_DLY;
                     n.tcnt  = '0;
                     n.acq   = 1'b0;
                     n.ch    = scan_first;
                     n.nleft = scan_cnt;
                     n.nconv = scan_cnt;
                     n.rep   = (scan_md == SCAN_REPEAT_N);
                     n.widx  = '0;
                     n.ridx  = '0;
                  end
               end
               if (sclk_fall) begin
                  if (q.state == S_CMD && q.rcnt == smp_ext) begin
                     n.acq = 1'b0;
                  end
                  if (q.state == S_CMD && q.rcnt == cmd_end) begin
                     n.state = S_EXT_RD;
                     n.sh    = {adc_result, 2'b00};
                  end else if (q.state == S_EXT_RD) begin
                     n.sh = {q.sh[14:0], 1'b0};
                  end
               end
            end
            S_OSC_DLY: begin
               n.tcnt = q.tcnt + 5'h01;
               if (q.tcnt == OSC_DLY_LAST) begin
                  n.state = S_INT_RUN;
                  n.osc   = 1'b1;
                  n.tcnt  = '0;
                  n.iclk  = 1'b0;
                  n.icnt  = '0;
               end
            end
            S_INT_RUN: begin
               n.tcnt = q.tcnt + 5'h01;
               if (q.tcnt == OSC_HALF_LAST) begin
                  n.tcnt = '0;
                  n.iclk = ~q.iclk;
                  if (!q.iclk) begin
                     n.icnt = q.icnt + 6'h01;
                     if (q.icnt + 6'h01 == ACQ_ON_INT) begin
                        n.acq = 1'b1;
                     end
                  end else begin
                     if (q.icnt == acq_end) begin
                        n.acq = 1'b0;
                     end
                     if (q.icnt == conv_end) begin
                        // Each result goes to the store at once
                        n.res  = adc_result;
                        n.wr   = 1'b1;
                        n.icnt = '0;
                        n.nleft = q.nleft - ONE_CH;
                        if (q.nleft == ONE_CH) begin
                           n.state = S_FINISH;
                           n.tcnt  = '0;
                        end else if (!q.rep) begin
                           n.ch = q.ch + CH_W'(1);
                        end
                     end
                  end
               end
            end
            S_FINISH: begin
               // Wait out the write and registered read
               n.tcnt = q.tcnt + 5'h01;
               if (q.tcnt == FIN_WAIT_LAST) begin
                  n.state = S_INT_RD;
                  n.eoc_n = 1'b0;
                  n.osc   = 1'b0;
                  n.awake = 1'b0;
                  n.iclk  = 1'b0;
                  n.sh    = {mem_rdata, 2'b00};
                  n.ridx  = ridx_next;
                  n.bcnt  = '0;
               end
            end
            S_INT_RD: begin
               if (sclk_fall) begin
                  if (q.bcnt == BIT_LAST) begin
                     // Loads the next result, wrapping to the first after the last
                     n.sh   = {mem_rdata, 2'b00};
                     n.ridx = ridx_next;
                     n.bcnt = '0;
                  end else begin
                     n.sh   = {q.sh[14:0], 1'b0};
                     n.bcnt = q.bcnt + 5'h01;
                  end
               end
            end
            default: begin
               n.state = S_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= ST_RST;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Outputs, all straight from state flops
   assign dout         = q.sh[15];
   assign dout_oe_n    = q.oe_n;
   assign eoc_n        = q.eoc_n;
   assign mux_channel  = q.ch;
   assign track        = q.acq;
   assign analog_awake = q.awake;
   assign osc_run      = q.osc;
   assign osc_clk      = q.iclk;
   assign command_reg  = q.cmd;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_cmd_active;
      q.state == S_CMD && !s_cs;
   endsequence

   sequence s_dly_enter;
      q.state != S_OSC_DLY ##1 q.state == S_OSC_DLY;
   endsequence

   oe_drive_a: assert property (
      cs_fall |=> (!q.oe_n && !q.sh[15]))
      else $error("data out not driven low after select");
   din_capture_a: assert property (
      (s_cmd_active and (sclk_rise && q.rcnt < CNT_W8))
      |=> q.shin[0] == $past(s_din))
      else $error("data in bit not captured on rise");
   chan_apply_a: assert property (
      (s_cmd_active and (sclk_rise && rnext == CNT_CH_APPLY))
      |=> q.ch == q.shin[CH_W-1:0])
      else $error("channel not applied on third rise");
   ext_sample_a: assert property (
      (s_cmd_active and (sclk_fall && q.rcnt == smp_ext))
      |=> !q.acq)
      else $error("acquisition not ended at sample fall");
   msb_load_a: assert property (
      (s_cmd_active and (sclk_fall && q.rcnt == cmd_end))
      |=> q.state == S_EXT_RD && q.sh == {$past(adc_result), 2'b00})
      else $error("result not loaded at command end fall");
   abort_a: assert property (
      s_cs |=> (q.state == S_OFF && q.oe_n && !q.osc && !q.awake))
      else $error("select high did not abort and shut down");
   osc_delay_a: assert property (
      s_dly_enter |-> !q.osc ##25 (q.osc || q.state == S_OFF))
      else $error("oscillator start delay wrong");
   eoc_done_a: assert property (
      $fell(q.eoc_n) |-> (!q.osc && !q.awake &&
                          q.sh[15:2] == mem_rdata))
      else $error("done fall without first result or shutdown");
   int_only_a: assert property (
      q.osc |-> q.cmd[CLKSRC_BIT])
      else $error("oscillator running in external clock mode");
   scan_hold_a: assert property (
      q.state == S_INT_RUN |-> q.eoc_n)
      else $error("done fell before last scan conversion");
endmodule
`default_nettype wire

// *** test/adcsc_host.sv ***
// Host serial master model: chip select, sclk, din, mode pins.
// Assumes the bench calls its tasks; sclk stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module adcsc_host (
   // Link pins
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   output logic      frame_sync_in,
   output logic      transfer_width_select,
   input  wire logic dout
);
   // ==========================================================
   // Idle levels
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
      frame_sync_in = 1'b1;
      transfer_width_select = 1'b0;
   end
   // ==========================================================
   // Frame tasks
   task automatic open_frame(input logic word);
      transfer_width_select = word;
      #10 cs_n = 1'b0;
   endtask
   // Data set while sclk low, dout taken at each rise
   task automatic clk_bits(input logic [15:0] w, input int n,
                           output logic [15:0] rd);
      rd = '0;
      for (int i = 0; i < n; i++) begin
         din = w[15-i];
         #24 sclk = 1'b1;
         rd = {rd[14:0], dout};
         #24 sclk = 1'b0;
      end
   endtask
   // Released din shows the inverse, not a stale value
   task automatic close_frame();
      #24 cs_n = 1'b1;
      din = ~din;
   endtask
endmodule
`default_nettype wire

// *** test/adcsc_tb.sv ***
// Testbench: host model drives frames, bench checks the pins.
// Assumes a 200 MHz sys_clk and an analog result keyed to channel.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adcsc_pkg::*;
   logic        sys_clk, reset_n, cs_n, sclk, din, dout, dout_oe_n;
   logic        eoc_n, fsync, wsel, track, awake, osc_run, osc_clk;
   logic [2:0]  mux_ch;
   logic [7:0]  cmd_reg;
   logic [15:0] rd;
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          ticks = 0;
   // ==========================================================
   // Analog core: result carries the channel it came from
   wire logic [RES_W-1:0] res = {mux_ch, 11'h2c5};
   adcsc_host host (.cs_n(cs_n), .sclk(sclk), .din(din),
      .frame_sync_in(fsync), .transfer_width_select(wsel), .dout(dout));
   adcsc_ctrl #(.NUM_CH(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe_n(dout_oe_n), .eoc_n(eoc_n), .frame_sync_in(fsync),
      .transfer_width_select(wsel), .adc_result(res),
      .mux_channel(mux_ch), .track(track), .analog_awake(awake),
      .osc_run(osc_run), .osc_clk(osc_clk), .command_reg(cmd_reg));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   function automatic logic [15:0] frame_of(input int ch);
      return {3'(ch), 11'h2c5, 2'b00};
   endfunction
   task automatic start(input logic [7:0] cmd, input logic word);
      host.open_frame(word);
      wait_clk(6);
      check({dout_oe_n, dout, awake}, 3'b001);
      host.clk_bits({cmd, 8'ha5}, 8, rd);
      wait_clk(5);
      check(cmd_reg, cmd);
   endtask
   task automatic ext_run(input logic [7:0] cmd, input logic word);
      start(cmd, word);
      check({mux_ch, osc_run, track}, {cmd[7:5], 1'b0, word});
      if (word) begin
         host.clk_bits(16'ha5a5, 8, rd);
         wait_clk(5);
         check(track, 1'b0);
      end
      host.clk_bits(16'h0, 16, rd);
      check(rd, frame_of(cmd[7:5]));
      host.clk_bits(16'ha5a5, 8, rd);
      check(rd, 16'h0);
      host.close_frame();
      wait_clk(6);
      check({dout_oe_n, awake}, 2'b10);
   endtask
   task automatic int_run(input logic [7:0] cmd, input logic word,
                          input int nres, ch0, step);
      int n;
      int lo;
      int t0;
      logic [15:0] f;
      start(cmd, word);
      if (word) host.clk_bits(16'ha5a5, 8, rd);
      wait_clk(5);
      check({mux_ch, osc_run}, {3'(ch0), 1'b0});
      n = 0;
      t0 = ticks;
      f = frame_of(ch0);
      lo = nres * (word ? 1600 : 1250);
      // Sclk stands still until done falls
      while (eoc_n !== 1'b0 && n < 20000) begin
         wait_clk(1);
         n++;
      end
      check(n >= lo && n <= lo + 40, 1'b1);
      check(ticks - t0, nres * (word ? 32 : 25));
      wait_clk(4);
      check({osc_run, awake, dout}, {2'b00, f[15]});
      // One frame past the last shows the wrap to the first
      for (int k = 0; k <= nres; k++) begin
         host.clk_bits(16'ha5a5, 16, rd);
         check(rd, frame_of(k < nres ? ch0 + k * step : ch0));
      end
      host.close_frame();
      wait_clk(6);
   endtask
   // ==========================================================
   // Clock, timeout and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         results();
      end
   end
   // Internal clock rises, one per internal cycle
   always @(posedge osc_clk) begin
      ticks++;
   end
   initial begin
      reset_n = 1'b0;
      wait_clk(6);
      check({dout_oe_n, eoc_n, cmd_reg}, {2'b11, CMD_RESET});
      reset_n = 1'b1;
      wait_clk(3);
      ext_run(8'hb6, 1'b0);
      ext_run(8'h5e, 1'b1);
      int_run(8'h67, 1'b0, 1, 3, 0);
      int_run(8'h2f, 1'b0, 2, 0, 1);
      int_run(8'hb7, 1'b0, 2, 4, 1);
      int_run(8'h5f, 1'b0, 8, 2, 0);
      int_run(8'he7, 1'b1, 1, 7, 0);
      // Abort while the oscillator runs
      start(8'h67, 1'b0);
      wait_clk(40);
      check(osc_run, 1'b1);
      host.close_frame();
      wait_clk(6);
      check({osc_run, osc_clk, awake, track, dout_oe_n}, 5'b00001);
      wait_clk(1500);
      check(eoc_n, 1'b1);
      results();
   end
endmodule
`default_nettype wire
